// *** lmc_pkg.sv ***
package lmc_pkg;

  localparam logic [5:0]  ROW_READ        = 6'h00;
  localparam logic [5:0]  ROW_WRITE       = 6'h01;
  localparam logic [5:0]  ROW_REFRESH     = 6'h02;
  localparam logic [5:0]  ROW_DEACT_ALL   = 6'h03;
  localparam logic [5:0]  ROW_PD_READ     = 6'h04;
  localparam logic [5:0]  ROW_PD_WRITE    = 6'h05;
  localparam logic [5:0]  ROW_BLOCK_WRITE = 6'h09;
  localparam logic [5:0]  ROW_MODE_SET    = 6'h0c;
  localparam logic [5:0]  ROW_LOAD_COLOR  = 6'h0d;
  localparam logic [3:0]  ROW_FRAME_BASE  = 4'h4;
  localparam logic [5:0]  ROW_PT_READ     = 6'h1c;
  localparam logic [5:0]  ROW_PT_WRITE    = 6'h1d;
  localparam logic [5:0]  CODE_IDLE       = 6'h1f;

  localparam logic [1:0]  COL_PP_BASE     = 2'h0;
  localparam logic [5:0]  COL_MP_LOW_PKT  = 6'h10;
  localparam logic [5:0]  COL_MP_HIGH_PKT = 6'h11;
  localparam logic [4:0]  COL_MP_URGENT   = 5'h09;
  localparam logic [4:0]  COL_MP_ICACHE   = 5'h0b;
  localparam logic [4:0]  COL_MP_DEA      = 5'h0c;
  localparam logic [4:0]  COL_MP_DCACHE   = 5'h0d;
  localparam logic [5:0]  COL_XPT_PROG    = 6'h14;
  localparam logic [5:0]  COL_XPT_DONE    = 6'h15;
  localparam logic [4:0]  COL_FRAME_BASE  = 5'h0e;
  localparam logic [5:0]  COL_REFRESH     = 6'h1e;
  localparam logic [5:0]  COL_DRAIN       = 6'h3f;

  localparam logic [4:0]  COL_SHIFT_BASE  = 5'h07;
  localparam logic [5:0]  RESET_STATUS    = CODE_IDLE;
  localparam logic [31:0] RESET_ADDR      = 32'h0000_0000;
  localparam logic [2:0]  RESET_SEL       = 3'h0;

  typedef enum logic [3:0] {
    RK_READ        = 4'h0,
    RK_WRITE       = 4'h1,
    RK_REFRESH     = 4'h2,
    RK_DEACT_ALL   = 4'h3,
    RK_PD_READ     = 4'h4,
    RK_PD_WRITE    = 4'h5,
    RK_BLOCK_WRITE = 4'h6,
    RK_MODE_SET    = 4'h7,
    RK_LOAD_COLOR  = 4'h8,
    RK_PT_READ     = 4'h9,
    RK_PT_WRITE    = 4'ha,
    RK_FRAME       = 4'hb,
    RK_XPT         = 4'hc,
    RK_IDLE        = 4'hd
  } lmc_row_kind_type;

  typedef enum logic [3:0] {
    CK_PP        = 4'h0,
    CK_MP_LOW    = 4'h1,
    CK_MP_HIGH   = 4'h2,
    CK_MP_URGENT = 4'h3,
    CK_MP_ICACHE = 4'h4,
    CK_MP_DEA    = 4'h5,
    CK_MP_DCACHE = 4'h6,
    CK_XPT_PROG  = 4'h7,
    CK_XPT_DONE  = 4'h8,
    CK_FRAME     = 4'h9,
    CK_REFRESH   = 4'ha,
    CK_IDLE      = 4'hb,
    CK_DRAIN     = 4'hc
  } lmc_col_kind_type;

  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,
    PH_ROW  = 2'b01,
    PH_COL  = 2'b10
  } lmc_phase_type;

  // Op: read, write, split or peripheral read, split or peripheral write
  typedef struct packed {
    lmc_row_kind_type kind;
    logic             frame;
    logic [2:0]       xpt_num;
    logic [1:0]       op;
    logic [31:0]      addr;
  } lmc_row_req_type;

  typedef struct packed {
    lmc_col_kind_type kind;
    logic [1:0]       pp_index;
    logic [1:0]       op;
    logic             frame;
    logic             mp_high;
    logic [31:0]      addr;
  } lmc_col_req_type;

  typedef struct packed {
    lmc_phase_type phase;
    logic [2:0]    sel_s1;
    logic [2:0]    sel_s2;
    logic [2:0]    sel;
    logic [5:0]    status;
    logic [31:0]   addr;
  } lmc_state_type;

endpackage

// *** lmc_status_addr_mux.sv ***
`timescale 1ns/1ps
module lmc_status_addr_mux (
  input  wire logic                     ref_clk,             // Device clock
  input  wire logic                     arst_n,              // Async reset
  input  wire logic                     cyc_start,           // Row phase go
  input  wire lmc_pkg::lmc_row_req_type row_req,             // Row request
  input  wire logic                     col_step,            // Column go
  input  wire lmc_pkg::lmc_col_req_type col_req,             // Column request
  input  wire logic                     cyc_end,             // Cycle done
  input  wire logic [2:0]               column_shift_select, // Pin input
  output logic [5:0]                    status_pins,         // Cycle code
  output logic [31:0]                   addr_pins,           // Address bus
  output logic                          row_phase,           // In row phase
  output logic                          col_phase            // In col phase
);

  ////////////////////////////////////////////////////////////////////////////

  function automatic logic [5:0] row_code(lmc_pkg::lmc_row_req_type r);
    logic [5:0] c;
    c = lmc_pkg::CODE_IDLE;
    case (r.kind)
      lmc_pkg::RK_READ:        c = lmc_pkg::ROW_READ;
      lmc_pkg::RK_WRITE:       c = lmc_pkg::ROW_WRITE;
      lmc_pkg::RK_REFRESH:     c = lmc_pkg::ROW_REFRESH;
      lmc_pkg::RK_DEACT_ALL:   c = lmc_pkg::ROW_DEACT_ALL;
      lmc_pkg::RK_PD_READ:     c = lmc_pkg::ROW_PD_READ;
      lmc_pkg::RK_PD_WRITE:    c = lmc_pkg::ROW_PD_WRITE;
      lmc_pkg::RK_BLOCK_WRITE: c = lmc_pkg::ROW_BLOCK_WRITE;
      lmc_pkg::RK_MODE_SET:    c = lmc_pkg::ROW_MODE_SET;
      lmc_pkg::RK_LOAD_COLOR:  c = lmc_pkg::ROW_LOAD_COLOR;
      lmc_pkg::RK_PT_READ:     c = lmc_pkg::ROW_PT_READ;
      lmc_pkg::RK_PT_WRITE:    c = lmc_pkg::ROW_PT_WRITE;
      lmc_pkg::RK_FRAME: begin
        c = {lmc_pkg::ROW_FRAME_BASE[3:1], r.frame, r.op};
      end
      lmc_pkg::RK_XPT: begin
        // Request number zero would land in reserved space
        if (r.xpt_num != 3'h0) begin
          c = {1'b1, r.xpt_num, r.op};
        end
      end
      default: c = lmc_pkg::CODE_IDLE;
    endcase
    return c;
  endfunction

  function automatic logic [5:0] col_code(lmc_pkg::lmc_col_req_type r);
    logic [5:0] c;
    c = lmc_pkg::CODE_IDLE;
    case (r.kind)
      lmc_pkg::CK_PP: begin
        c = {lmc_pkg::COL_PP_BASE, r.pp_index, r.op};
      end
      lmc_pkg::CK_MP_LOW:    c = lmc_pkg::COL_MP_LOW_PKT;
      lmc_pkg::CK_MP_HIGH:   c = lmc_pkg::COL_MP_HIGH_PKT;
      lmc_pkg::CK_MP_URGENT: c = {lmc_pkg::COL_MP_URGENT, r.mp_high};
      lmc_pkg::CK_MP_ICACHE: c = {lmc_pkg::COL_MP_ICACHE, r.mp_high};
      lmc_pkg::CK_MP_DEA:    c = {lmc_pkg::COL_MP_DEA, r.mp_high};
      lmc_pkg::CK_MP_DCACHE: c = {lmc_pkg::COL_MP_DCACHE, r.mp_high};
      lmc_pkg::CK_XPT_PROG:  c = lmc_pkg::COL_XPT_PROG;
      lmc_pkg::CK_XPT_DONE:  c = lmc_pkg::COL_XPT_DONE;
      lmc_pkg::CK_FRAME:     c = {lmc_pkg::COL_FRAME_BASE, r.frame};
      lmc_pkg::CK_REFRESH:   c = lmc_pkg::COL_REFRESH;
      lmc_pkg::CK_DRAIN:     c = lmc_pkg::COL_DRAIN;
      default:               c = lmc_pkg::CODE_IDLE;
    endcase
    return c;
  endfunction

  // Undefined pins between the shifted field and bits 2:0 drive zero
  function automatic logic [31:0] col_mux(logic [31:0] a, logic [2:0] s);
    logic [4:0]  amt;
    logic [31:0] r;
    amt = lmc_pkg::COL_SHIFT_BASE + {2'h0, s};
    r   = a;
    if (s != 3'h0) begin
      r = (a << amt) | {29'h0, a[2:0]};
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////

  lmc_pkg::lmc_state_type st_q;
  lmc_pkg::lmc_state_type st_d;
  logic [5:0]             row_code_c;
  logic [5:0]             col_code_c;
  logic [31:0]            col_addr_c;
  logic [31:0]            row_addr_w;
  logic [31:0]            col_in_addr_w;
  logic                   take_row;
  logic                   take_col;
  logic                   take_end;

  assign row_code_c    = row_code(row_req);
  assign col_code_c    = col_code(col_req);
  assign col_addr_c    = col_mux(col_req.addr, st_q.sel);
  assign row_addr_w    = row_req.addr;
  assign col_in_addr_w = col_req.addr;
  assign take_row = (st_q.phase == lmc_pkg::PH_IDLE) && cyc_start;
  assign take_col = (st_q.phase != lmc_pkg::PH_IDLE) && col_step;
  // A column step in the same cycle as the end wins; the end is dropped
  assign take_end = (st_q.phase != lmc_pkg::PH_IDLE) && cyc_end && !col_step;

  always_comb begin
    st_d        = st_q;
    st_d.sel_s1 = column_shift_select;
    st_d.sel_s2 = st_q.sel_s1;
    case (st_q.phase)
      lmc_pkg::PH_IDLE: begin
        if (take_row) begin
          st_d.phase  = lmc_pkg::PH_ROW;
          st_d.status = row_code_c;
          st_d.addr   = row_req.addr;
          st_d.sel    = st_q.sel_s2;
        end
      end
      lmc_pkg::PH_ROW, lmc_pkg::PH_COL: begin
        if (take_col) begin
          st_d.phase  = lmc_pkg::PH_COL;
          st_d.status = col_code_c;
          st_d.addr   = col_addr_c;
        end else if (take_end) begin
          st_d.phase  = lmc_pkg::PH_IDLE;
          st_d.status = lmc_pkg::CODE_IDLE;
        end
      end
      default: begin
        st_d.phase  = lmc_pkg::PH_IDLE;
        st_d.status = lmc_pkg::CODE_IDLE;
      end
    endcase
  end

  // All but the select sync stages holds between events, so pins only move at boundaries
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_q.phase  <= lmc_pkg::PH_IDLE;
      st_q.sel_s1 <= lmc_pkg::RESET_SEL;
      st_q.sel_s2 <= lmc_pkg::RESET_SEL;
      st_q.sel    <= lmc_pkg::RESET_SEL;
      st_q.status <= lmc_pkg::RESET_STATUS;
      st_q.addr   <= lmc_pkg::RESET_ADDR;
    end else begin
      st_q <= st_d;
    end
  end

  assign status_pins = st_q.status;
  assign addr_pins   = st_q.addr;
  // Row and column phase codes are one-hot, so each flag is a state flop bit itself
  assign row_phase   = st_q.phase[0];
  assign col_phase   = st_q.phase[1];

  ////////////////////////////////////////////////////////////////////////////

  function automatic logic row_legal(logic [5:0] c);
    logic ok;
    ok = 1'b1;
    if ((c inside {6'h06, 6'h07, 6'h08, 6'h0a, 6'h0b, 6'h0e, 6'h0f,
                   6'h1e}) || (c[5:2] == 4'h6) || (c[5:2] == 4'h8)) begin
      ok = 1'b0;
    end
    return ok;
  endfunction

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);

  sequence row_taken_s;
    take_row;
  endsequence

  sequence col_taken_s;
    take_col;
  endsequence

  // Request number zero must fall back to idle, not reserved space
  sequence xpt_zero_s;
    take_row && (row_req.kind == lmc_pkg::RK_XPT) &&
      (row_req.xpt_num == 3'h0);
  endsequence

  sequence xpt_some_s;
    take_row && (row_req.kind == lmc_pkg::RK_XPT) &&
      (row_req.xpt_num != 3'h0);
  endsequence

  row_code_a: assert property (row_taken_s |=> row_phase &&
    status_pins == $past(row_code_c)) else $error("row code wrong");
  row_addr_a: assert property (row_taken_s |=> addr_pins ==
    $past(row_addr_w)) else $error("row address not full");
  col_code_a: assert property (col_taken_s |=> col_phase &&
    status_pins == $past(col_code_c)) else $error("column code wrong");
  col_zero_a: assert property ((col_taken_s and
    (st_q.sel == 3'h0)) |=> addr_pins == $past(col_in_addr_w))
    else $error("unshifted column address wrong");
  col_shift_a: assert property ((col_taken_s and
    (st_q.sel == 3'h1)) |=> addr_pins[31:8] == $past(col_in_addr_w[23:0])
    && addr_pins[2:0] == $past(col_in_addr_w[2:0]))
    else $error("shifted column address wrong");
  sel_hold_a: assert property (row_taken_s ##1 (!take_end)[*2]
    |-> $stable(st_q.sel)) else $error("shift select moved");
  pins_stable_a: assert property (!take_row && !take_col
    && !take_end |=> $stable(status_pins) && $stable(addr_pins))
    else $error("pins moved inside a phase");
  no_reserved_a: assert property ((row_phase -> row_legal(status_pins))
    && (col_phase -> (!status_pins[5] || status_pins == 6'h3f)))
    else $error("reserved code driven");
  mp_pair_a: assert property ((col_taken_s and
    (col_req.kind inside {lmc_pkg::CK_MP_URGENT, lmc_pkg::CK_MP_DEA}))
    |=> status_pins[0] == $past(col_req.mp_high))
    else $error("priority pairing wrong");
  end_idle_a: assert property (take_end |=> !row_phase && !col_phase
    && status_pins == 6'h1f) else $error("idle not shown");
  row_xpt_a: assert property (xpt_some_s |=> status_pins[5] &&
    status_pins[4:2] == $past(row_req.xpt_num))
    else $error("packet row code wrong");
  xpt_zero_a: assert property (xpt_zero_s |=>
    status_pins == 6'h1f) else $error("zero packet not idle");
  sel_take_a: assert property (row_taken_s |=>
    st_q.sel == $past(st_q.sel_s2)) else $error("select not latched");

endmodule

// *** lmc_mem_model.sv ***
`timescale 1ns/1ps
module lmc_mem_model (
  input  wire logic       ref_clk,             // Device clock
  input  wire logic       arst_n,              // Async reset
  input  wire logic [2:0] sel_cfg,             // Board strap value
  input  wire logic       row_phase,           // Row strobe seen
  input  wire logic [5:0] status_pins,         // Cycle code
  output logic      [2:0] column_shift_select, // Select pins
  output logic      [5:0] bank_code_q          // Latched row code
);
  logic row_seen_q;
  // Strap is launched off the edge so it never races the device flops
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      column_shift_select <= 3'h0;
      bank_code_q         <= 6'h1f;
      row_seen_q          <= 1'b0;
    end else begin
      column_shift_select <= sel_cfg;
      row_seen_q          <= row_phase;
      if (row_phase && !row_seen_q) begin
        bank_code_q <= status_pins;
      end
    end
  end
endmodule

// *** lmc_status_addr_mux_tb.sv ***
`timescale 1ns/1ps
module lmc_status_addr_mux_tb;
  logic ref_clk, arst_n, cyc_start, col_step, cyc_end;
  logic        due = 1'b0;
  logic [5:0]  bank_code, bank_exp;
  lmc_pkg::lmc_row_req_type row_req;
  lmc_pkg::lmc_col_req_type col_req;
  logic [2:0]  sel_cfg, column_shift_select;
  logic [5:0]  status_pins;
  logic [31:0] addr_pins, rnd;
  logic        row_phase, col_phase;
  logic [39:0] exp_q[$];
  logic [39:0] last_exp;
  logic [39:0] held = {6'h1f, 32'h0, 2'b00};
  logic [5:0]  rcode [12] = '{6'h00, 6'h01, 6'h02, 6'h03, 6'h04, 6'h05,
                             6'h09, 6'h0c, 6'h0d, 6'h1c, 6'h1d, 6'h1f};
  int n_mismatch = 0;
  int samples_checked = 0;
  int cycles = 0;

  lmc_status_addr_mux DUT (.ref_clk(ref_clk), .arst_n(arst_n),
    .cyc_start(cyc_start), .row_req(row_req), .col_step(col_step),
    .col_req(col_req), .cyc_end(cyc_end),
    .column_shift_select(column_shift_select), .status_pins(status_pins),
    .addr_pins(addr_pins), .row_phase(row_phase), .col_phase(col_phase));
  lmc_mem_model mem (.ref_clk(ref_clk), .arst_n(arst_n), .sel_cfg(sel_cfg),
    .row_phase(row_phase), .status_pins(status_pins),
    .column_shift_select(column_shift_select), .bank_code_q(bank_code));

  ////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [31:0] mux(input logic [31:0] a,
                                      input logic [2:0] s);
    if (s == 3'h0) return a;
    return (a << (7 + s)) | {29'h0, a[2:0]};
  endfunction
  function automatic logic [5:0] expc(input int k, input logic [3:0] v);
    case (k)
      0: return {2'b00, v};
      1: return 6'h10;
      2: return 6'h11;
      3: return {5'h09, v[0]};
      4: return {5'h0b, v[0]};
      5: return {5'h0c, v[0]};
      6: return {5'h0d, v[0]};
      7: return 6'h14;
      8: return 6'h15;
      9: return {5'h0e, v[0]};
      10: return 6'h1e;
      11: return 6'h1f;
      default: return 6'h3f;
    endcase
  endfunction
  task automatic chk(input string what, input logic [39:0] e,
                     input logic [39:0] g);
    samples_checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic row(input int k, input logic fr, input logic [2:0] n,
                     input logic [1:0] op, input logic [5:0] code);
    @(posedge ref_clk);
    rnd = lfsr(rnd);
    row_req <= '{kind: lmc_pkg::lmc_row_kind_type'(k), frame: fr,
                 xpt_num: n, op: op, addr: rnd};
    {cyc_start, col_step, cyc_end} <= 3'b100;
    exp_q.push_back({code, rnd, 2'b10});
    last_exp = {code, rnd, 2'b10};
    bank_exp = code;
  endtask
  task automatic col(input int k, input logic [3:0] v);
    @(posedge ref_clk);
    rnd = lfsr(rnd);
    col_req <= '{kind: lmc_pkg::lmc_col_kind_type'(k), pp_index: v[3:2],
                 op: v[1:0], frame: v[0], mp_high: v[0], addr: rnd};
    {cyc_start, col_step, cyc_end} <= 3'b010;
    last_exp = {expc(k, v), mux(rnd, sel_cfg), 2'b01};
    exp_q.push_back(last_exp);
  endtask
  task automatic fin();
    @(posedge ref_clk);
    {cyc_start, col_step, cyc_end} <= 3'b001;
    last_exp = {6'h1f, last_exp[33:2], 2'b00};
    exp_q.push_back(last_exp);
    @(posedge ref_clk);
    {cyc_start, col_step, cyc_end} <= 3'b000;
    // The model latched the row code on the first row-phase edge
    @(negedge ref_clk);
    chk("bank code", {34'h0, bank_exp}, {34'h0, bank_code});
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  // Outputs must only move one cycle after a taken strobe
  always @(posedge ref_clk) begin
    due <= cyc_start | col_step | cyc_end;
    cycles++;
    if (cycles > 3000) begin
      n_mismatch++;
      close_out();
    end
  end
  always @(negedge ref_clk) begin
    if (due && exp_q.size() > 0) begin
      held = exp_q.pop_front();
      chk("outputs", held, {status_pins, addr_pins, row_phase, col_phase});
    end else if (!due) begin
      chk("hold", held, {status_pins, addr_pins, row_phase, col_phase});
    end
  end

  initial begin
    {cyc_start, col_step, cyc_end} = 3'b000;
    row_req = '0;
    col_req = '0;
    sel_cfg = 3'h3;
    arst_n = 1'b0;
    rnd = 32'h0000_0053;
    repeat (6) @(posedge ref_clk);
    arst_n <= 1'b1;
    repeat (4) @(posedge ref_clk);
    for (int k = 0; k < 12; k++) begin
      row((k == 11) ? 13 : k, 1'b0, 3'h0, 2'h0, rcode[k]);
      col(0, k[3:0]);
      fin();
    end
    $display("test row kinds done");
    for (int f = 0; f < 8; f++) begin
      row(11, f[2], 3'h0, f[1:0], {3'b010, f[2:0]});
      fin();
    end
    for (int x = 0; x < 32; x++) begin
      row(12, 1'b0, x[4:2], x[1:0],
          (x < 4) ? 6'h1f : {1'b1, x[4:0]});
      fin();
    end
    $display("test frame and packet rows done");
    row(0, 1'b0, 3'h0, 2'h0, 6'h00);
    for (int c = 0; c < 208; c++) begin
      col(c / 16, c[3:0]);
    end
    @(posedge ref_clk);
    {cyc_start, col_step, cyc_end} <= 3'b100;
    exp_q.push_back(last_exp);
    fin();
    $display("test column codes done");
    for (int s = 0; s < 8; s++) begin
      @(posedge ref_clk);
      sel_cfg <= s[2:0];
      repeat (4) @(posedge ref_clk);
      row(1, 1'b0, 3'h0, 2'h0, 6'h01);
      col(7, 4'h0);
      col(8, 4'h0);
      fin();
    end
    $display("test column shift done");
    repeat (3) @(posedge ref_clk);
    close_out();
  end
endmodule
